// ---- design/fmc_pkg.sv ----
package fmc_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_INSTR = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_DST_LO = 8'h10;
  localparam logic [7:0] OFF_DST_HI = 8'h14;
  localparam logic [7:0] OFF_SRC_LO = 8'h18;
  localparam logic [7:0] OFF_SRC_HI = 8'h1c;
  localparam logic [7:0] OFF_CNT_LO = 8'h20;
  localparam logic [7:0] OFF_CNT_HI = 8'h24;

  // control register bits
  localparam int CTRL_START = 0;
  localparam int CTRL_ALGO_B = 1;
  localparam int CTRL_NOP_ON_CLASH = 2;
  localparam int CTRL_FEATURE = 3;

  // status register bits
  localparam int STS_BUSY = 0;
  localparam int STS_DONE = 1;
  localparam int STS_UNDEF = 2;
  localparam int STS_NOP = 3;
  localparam int STS_PARAM_ERR = 4;
  localparam int STS_FAULT = 5;
  localparam int STS_FAULT_WRITE = 6;
  localparam int STS_OTHER_GROUP = 7;

  // instruction field positions
  localparam int SZ_HI = 31;
  localparam int SZ_LO = 30;
  localparam int OP1_HI = 23;
  localparam int OP1_LO = 22;
  localparam int RS_HI = 20;
  localparam int RS_LO = 16;
  localparam int OP2_HI = 15;
  localparam int OP2_LO = 12;
  localparam int RN_HI = 9;
  localparam int RN_LO = 5;
  localparam int RD_HI = 4;
  localparam int RD_LO = 0;

  // option field bits
  localparam int OPT_RD_NT = 3;
  localparam int OPT_WR_NT = 2;
  localparam int OPT_RD_UNPRIV = 1;
  localparam int OPT_WR_UNPRIV = 0;

  localparam logic [1:0] SIZE_OK = 2'h0;
  localparam logic [4:0] REG_ZR = 5'h1f;
  localparam int SIGN_BIT = 63;
  localparam int FLAG_C = 1;
  localparam logic [3:0] NZCV_ALGO_A = 4'h0;
  localparam logic [3:0] NZCV_ALGO_B = 4'h2;
  localparam logic [63:0] SAT_MAX = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] ZERO64 = 64'h0;
  localparam logic [63:0] ONE64 = 64'h1;

  typedef enum logic [1:0] {
    STG_PRO = 2'b00,
    STG_MAIN = 2'b01,
    STG_EPI = 2'b10,
    STG_OTHER = 2'b11
  } fmc_stage_e_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_BLOCK = 3'b010,
    ST_STEP = 3'b011,
    ST_READ = 3'b100,
    ST_WRITE = 3'b101,
    ST_FINISH = 3'b110
  } fmc_fsm_e_t;

  typedef struct packed {
    fmc_stage_e_t stage;
    logic sizeOk;
    logic [3:0] opt;
    logic [4:0] rd;
    logic [4:0] rs;
    logic [4:0] rn;
    logic clash;
  } fmc_decode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [63:0] addr;
    logic [7:0] wdata;
    logic privileged;
    logic nonTemporal;
  } fmc_mem_req_t;

  typedef struct packed {
    logic ack;
    logic fault;
    logic [7:0] rdata;
  } fmc_mem_rsp_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fmc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fmc_apb_rsp_t;

endpackage

// ---- design/fmc_decode.sv ----
`timescale 1ns/1ps
module fmc_decode
  import fmc_pkg::*;
(
  // instruction word
  input wire logic [31:0] instr,
  // decoded fields
  output fmc_decode_t dec
);

  always_comb
  begin
    dec.stage = fmc_stage_e_t'(instr[OP1_HI:OP1_LO]);
    dec.sizeOk = instr[SZ_HI:SZ_LO] == SIZE_OK;
    dec.opt = instr[OP2_HI:OP2_LO];
    dec.rd = instr[RD_HI:RD_LO];
    dec.rs = instr[RS_HI:RS_LO];
    dec.rn = instr[RN_HI:RN_LO];
    dec.clash = (dec.rs == dec.rn) || (dec.rs == dec.rd) || (dec.rn == dec.rd)
      || (dec.rd == REG_ZR) || (dec.rs == REG_ZR) || (dec.rn == REG_ZR);
  end

endmodule

// ---- design/fmc_block_size.sv ----
`timescale 1ns/1ps
module fmc_block_size
  import fmc_pkg::*;
#(
  parameter int BLOCK_MAX = 8
)
(
  // bytes left in the stage
  input wire logic [63:0] stageLeft,
  // bytes for the next block
  output logic [63:0] blockSize
);

  localparam logic [63:0] MAX_BYTES = 64'(BLOCK_MAX);

  if (BLOCK_MAX < 1)
  begin
    $error("fmc_block_size: BLOCK_MAX must be at least 1");
  end

  assign blockSize = (stageLeft < MAX_BYTES) ? stageLeft : MAX_BYTES;

endmodule

// ---- design/fmc_copy_engine.sv ----
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module fmc_copy_engine
  import fmc_pkg::*;
#(
  parameter int BLOCK_MAX = 8,
  parameter logic [63:0] PRO_LIMIT = 64'h0000_0000_0000_0010
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire fmc_apb_req_t apbReq,
  output fmc_apb_rsp_t apbRsp,
  // memory system
  output fmc_mem_req_t memReq,
  input wire fmc_mem_rsp_t memRsp,
  // core context
  input wire logic atLowestLevel,
  // status pins
  output logic busy,
  output logic abortPulse,
  output logic abortWrite
);

  typedef struct packed {
    fmc_fsm_e_t fsm;
    logic algoB;
    logic nopOnClash;
    logic featOn;
    logic [31:0] instr;
    logic [3:0] nzcv;
    logic [63:0] dst;
    logic [63:0] src;
    logic [63:0] cnt;
    logic [63:0] stageLeft;
    logic [63:0] blockLeft;
    logic [7:0] status;
    fmc_mem_req_t memReq;
    logic [31:0] prdata;
    logic abortPulse;
    logic abortWrite;
  } fmc_state_t;

  if (PRO_LIMIT == ZERO64)
  begin
    $error("fmc_copy_engine: PRO_LIMIT must be nonzero");
  end

  fmc_state_t state_reg;
  fmc_state_t state_next;
  fmc_decode_t dec;
  logic [63:0] blockSize;
  logic [63:0] satCnt;
  logic [63:0] stageCap;
  logic [63:0] rdAddr;
  logic [63:0] wrAddr;
  logic apbSetup;
  logic apbAccess;
  logic addrMapped;
  logic busyNow;
  logic startReq;
  logic useB;
  logic badArgs;
  logic rdPriv;
  logic wrPriv;

  fmc_decode u_decode
  (
    .instr(state_reg.instr),
    .dec(dec)
  );

  fmc_block_size #(
    .BLOCK_MAX(BLOCK_MAX)
  ) u_block_size
  (
    .stageLeft(state_reg.stageLeft),
    .blockSize(blockSize)
  );

  assign apbSetup = apbReq.psel && !apbReq.penable;
  assign apbAccess = apbReq.psel && apbReq.penable;
  assign busyNow = state_reg.fsm != ST_IDLE;
  // carry tells which algorithm the running copy uses
  assign useB = state_reg.nzcv[FLAG_C];
  assign satCnt = state_reg.cnt[SIGN_BIT] ? SAT_MAX : state_reg.cnt;
  assign stageCap = (satCnt < PRO_LIMIT) ? satCnt : PRO_LIMIT;
  // algorithm A keeps base+offset, B keeps the plain lowest address
  assign rdAddr = useB ? state_reg.src : state_reg.src + state_reg.cnt;
  assign wrAddr = useB ? state_reg.dst : state_reg.dst + state_reg.cnt;
  // main and epilogue must match the carry and the sign of the count
  assign badArgs = (useB != state_reg.algoB)
    || (useB ? state_reg.cnt[SIGN_BIT]
             : (!state_reg.cnt[SIGN_BIT] && state_reg.cnt != ZERO64));
  // a clear option bit keeps the current level's privilege
  assign rdPriv = dec.opt[OPT_RD_UNPRIV] ? 1'b0 : !atLowestLevel;
  assign wrPriv = dec.opt[OPT_WR_UNPRIV] ? 1'b0 : !atLowestLevel;

  always_comb
  begin
    if (apbReq.paddr == OFF_CTRL)
    begin
      addrMapped = 1'b1;
    end
    else if (apbReq.paddr == OFF_STATUS || apbReq.paddr == OFF_INSTR)
    begin
      addrMapped = 1'b1;
    end
    else if (apbReq.paddr == OFF_FLAGS)
    begin
      addrMapped = 1'b1;
    end
    else if (apbReq.paddr == OFF_DST_LO || apbReq.paddr == OFF_DST_HI)
    begin
      addrMapped = 1'b1;
    end
    else if (apbReq.paddr == OFF_SRC_LO || apbReq.paddr == OFF_SRC_HI)
    begin
      addrMapped = 1'b1;
    end
    else if (apbReq.paddr == OFF_CNT_LO || apbReq.paddr == OFF_CNT_HI)
    begin
      addrMapped = 1'b1;
    end
    else
    begin
      addrMapped = 1'b0;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.abortPulse = 1'b0;
    startReq = 1'b0;

    // read data is captured in the setup cycle so prdata comes from a flop
    if (apbSetup)
    begin
      state_next.prdata = '0;
      if (apbReq.paddr == OFF_CTRL)
      begin
        state_next.prdata[CTRL_ALGO_B] = state_reg.algoB;
        state_next.prdata[CTRL_NOP_ON_CLASH] = state_reg.nopOnClash;
        state_next.prdata[CTRL_FEATURE] = state_reg.featOn;
      end
      else if (apbReq.paddr == OFF_STATUS)
      begin
        state_next.prdata[7:0] = state_reg.status;
        state_next.prdata[STS_BUSY] = busyNow;
      end
      else if (apbReq.paddr == OFF_INSTR)
      begin
        state_next.prdata = state_reg.instr;
      end
      else if (apbReq.paddr == OFF_FLAGS)
      begin
        state_next.prdata[3:0] = state_reg.nzcv;
      end
      else if (apbReq.paddr == OFF_DST_LO)
      begin
        state_next.prdata = state_reg.dst[31:0];
      end
      else if (apbReq.paddr == OFF_DST_HI)
      begin
        state_next.prdata = state_reg.dst[63:32];
      end
      else if (apbReq.paddr == OFF_SRC_LO)
      begin
        state_next.prdata = state_reg.src[31:0];
      end
      else if (apbReq.paddr == OFF_SRC_HI)
      begin
        state_next.prdata = state_reg.src[63:32];
      end
      else if (apbReq.paddr == OFF_CNT_LO)
      begin
        state_next.prdata = state_reg.cnt[31:0];
      end
      else if (apbReq.paddr == OFF_CNT_HI)
      begin
        state_next.prdata = state_reg.cnt[63:32];
      end
    end

    // operands are frozen while a copy runs; such writes answer with pslverr
    if (apbAccess && apbReq.pwrite && addrMapped && !busyNow)
    begin
      if (apbReq.paddr == OFF_CTRL)
      begin
        state_next.algoB = apbReq.pwdata[CTRL_ALGO_B];
        state_next.nopOnClash = apbReq.pwdata[CTRL_NOP_ON_CLASH];
        state_next.featOn = apbReq.pwdata[CTRL_FEATURE];
        startReq = apbReq.pwdata[CTRL_START];
      end
      else if (apbReq.paddr == OFF_INSTR)
      begin
        state_next.instr = apbReq.pwdata;
      end
      else if (apbReq.paddr == OFF_FLAGS)
      begin
        state_next.nzcv = apbReq.pwdata[3:0];
      end
      else if (apbReq.paddr == OFF_DST_LO)
      begin
        state_next.dst[31:0] = apbReq.pwdata;
      end
      else if (apbReq.paddr == OFF_DST_HI)
      begin
        state_next.dst[63:32] = apbReq.pwdata;
      end
      else if (apbReq.paddr == OFF_SRC_LO)
      begin
        state_next.src[31:0] = apbReq.pwdata;
      end
      else if (apbReq.paddr == OFF_SRC_HI)
      begin
        state_next.src[63:32] = apbReq.pwdata;
      end
      else if (apbReq.paddr == OFF_CNT_LO)
      begin
        state_next.cnt[31:0] = apbReq.pwdata;
      end
      else if (apbReq.paddr == OFF_CNT_HI)
      begin
        state_next.cnt[63:32] = apbReq.pwdata;
      end
    end

    case (state_reg.fsm)
      ST_IDLE:
      begin
        if (startReq)
        begin
          state_next.status = '0;
          state_next.fsm = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        if (!state_reg.featOn || !dec.sizeOk)
        begin
          state_next.status[STS_UNDEF] = 1'b1;
          state_next.status[STS_DONE] = 1'b1;
          state_next.fsm = ST_IDLE;
        end
        else if (dec.stage == STG_OTHER)
        begin
          state_next.status[STS_OTHER_GROUP] = 1'b1;
          state_next.status[STS_DONE] = 1'b1;
          state_next.fsm = ST_IDLE;
        end
        else if (dec.clash)
        begin
          state_next.status[STS_NOP] = state_reg.nopOnClash;
          state_next.status[STS_UNDEF] = !state_reg.nopOnClash;
          state_next.status[STS_DONE] = 1'b1;
          state_next.fsm = ST_IDLE;
        end
        else if (dec.stage == STG_PRO)
        begin
          if (!state_reg.algoB)
          begin
            state_next.nzcv = NZCV_ALGO_A;
            state_next.dst = state_reg.dst + satCnt;
            state_next.src = state_reg.src + satCnt;
            state_next.cnt = ZERO64 - satCnt;
          end
          else
          begin
            state_next.nzcv = NZCV_ALGO_B;
            state_next.cnt = satCnt;
          end
          state_next.stageLeft = stageCap;
          state_next.fsm = ST_BLOCK;
        end
        else if (badArgs)
        begin
          state_next.status[STS_PARAM_ERR] = 1'b1;
          state_next.status[STS_DONE] = 1'b1;
          state_next.fsm = ST_IDLE;
        end
        else
        begin
          // main and epilogue both run the whole remainder
          state_next.stageLeft = useB ? state_reg.cnt : ZERO64 - state_reg.cnt;
          state_next.fsm = ST_BLOCK;
        end
      end
      ST_BLOCK:
      begin
        if (state_reg.stageLeft == ZERO64)
        begin
          state_next.fsm = ST_FINISH;
        end
        else
        begin
          state_next.blockLeft = blockSize;
          state_next.fsm = ST_STEP;
        end
      end
      ST_STEP:
      begin
        if (state_reg.blockLeft == ZERO64)
        begin
          state_next.fsm = ST_BLOCK;
        end
        else
        begin
          state_next.memReq.valid = 1'b1;
          state_next.memReq.write = 1'b0;
          state_next.memReq.addr = rdAddr;
          state_next.memReq.privileged = rdPriv;
          state_next.memReq.nonTemporal = dec.opt[OPT_RD_NT];
          state_next.fsm = ST_READ;
        end
      end
      ST_READ:
      begin
        if (memRsp.ack)
        begin
          if (memRsp.fault)
          begin
            state_next.memReq.valid = 1'b0;
            state_next.status[STS_FAULT] = 1'b1;
            state_next.status[STS_FAULT_WRITE] = 1'b0;
            state_next.abortPulse = 1'b1;
            state_next.abortWrite = 1'b0;
            state_next.fsm = ST_FINISH;
          end
          else
          begin
            state_next.memReq.write = 1'b1;
            state_next.memReq.addr = wrAddr;
            state_next.memReq.wdata = memRsp.rdata;
            state_next.memReq.privileged = wrPriv;
            state_next.memReq.nonTemporal = dec.opt[OPT_WR_NT];
            state_next.fsm = ST_WRITE;
          end
        end
      end
      ST_WRITE:
      begin
        if (memRsp.ack)
        begin
          state_next.memReq.valid = 1'b0;
          if (memRsp.fault)
          begin
            state_next.status[STS_FAULT] = 1'b1;
            state_next.status[STS_FAULT_WRITE] = 1'b1;
            state_next.abortPulse = 1'b1;
            state_next.abortWrite = 1'b1;
            state_next.fsm = ST_FINISH;
          end
          else
          begin
            // progress is kept per byte so a fault leaves exact progress
            if (useB)
            begin
              state_next.src = state_reg.src + ONE64;
              state_next.dst = state_reg.dst + ONE64;
              state_next.cnt = state_reg.cnt - ONE64;
            end
            else
            begin
              state_next.cnt = state_reg.cnt + ONE64;
            end
            state_next.stageLeft = state_reg.stageLeft - ONE64;
            state_next.blockLeft = state_reg.blockLeft - ONE64;
            state_next.fsm = ST_STEP;
          end
        end
      end
      ST_FINISH:
      begin
        if (dec.stage == STG_EPI && !state_reg.status[STS_FAULT])
        begin
          state_next.cnt = ZERO64;
        end
        state_next.status[STS_DONE] = 1'b1;
        state_next.fsm = ST_IDLE;
      end
      default:
      begin
        state_next.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign apbRsp.prdata = state_reg.prdata;
  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = apbAccess && (!addrMapped || (apbReq.pwrite && busyNow));
  assign memReq = state_reg.memReq;
  assign busy = busyNow;
  assign abortPulse = state_reg.abortPulse;
  assign abortWrite = state_reg.abortWrite;

endmodule

// ---- tb/fmc_copy_engine_asserts.sv ----
`timescale 1ns/1ps
module fmc_copy_engine_asserts
  import fmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb
  input wire fmc_apb_req_t apbReq,
  input wire fmc_apb_rsp_t apbRsp,
  // memory
  input wire fmc_mem_req_t memReq,
  input wire fmc_mem_rsp_t memRsp,
  // context and status
  input wire logic atLowestLevel,
  input wire logic busy,
  input wire logic abortPulse,
  input wire logic abortWrite
);
  logic faultWasWrite;
  wire logic memDone = memReq.valid && memRsp.ack;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      faultWasWrite <= 1'b0;
    else if (memDone && memRsp.fault)
      faultWasWrite <= memReq.write;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_req_held: assert property (memReq.valid && !memRsp.ack |=> memReq.valid
    && $stable(memReq.addr) && $stable(memReq.write)) else $error("request moved before ack");
  a_read_then_write: assert property (memDone && !memReq.write && !memRsp.fault |=>
    memReq.valid && memReq.write && memReq.wdata == $past(memRsp.rdata))
    else $error("read byte not written next");
  a_write_needs_read: assert property ($rose(memReq.valid && memReq.write) |->
    $past(memDone && !memReq.write)) else $error("write without read");
  a_abort_follows: assert property (memDone && memRsp.fault |=> !memReq.valid ##[0:1]
    abortPulse) else $error("fault not aborted");
  a_abort_kind: assert property (abortPulse |-> abortWrite == faultWasWrite)
    else $error("abort kind wrong");
  a_abort_single: assert property (abortPulse |=> !abortPulse)
    else $error("abort pulse too long");
  a_unpriv_low: assert property (memReq.valid && atLowestLevel |-> !memReq.privileged)
    else $error("privileged access at lowest level");
  a_idle_quiet: assert property (!busy |-> !memReq.valid)
    else $error("memory access while idle");
  a_pready_high: assert property (apbReq.psel |-> apbRsp.pready) else $error("pready low");
  a_busy_write_err: assert property (apbReq.psel && apbReq.penable && apbReq.pwrite && busy
    |-> apbRsp.pslverr) else $error("write while busy accepted");
  cover property (abortPulse && abortWrite);
  cover property (abortPulse && !abortWrite);
  cover property (memDone && memReq.write);
  cover property (apbRsp.pslverr && apbReq.penable);
endmodule

bind fmc_copy_engine fmc_copy_engine_asserts chk_u (.clk(clk), .reset_n(reset_n),
  .apbReq(apbReq), .apbRsp(apbRsp), .memReq(memReq), .memRsp(memRsp),
  .atLowestLevel(atLowestLevel), .busy(busy), .abortPulse(abortPulse),
  .abortWrite(abortWrite));

// ---- tb/fmc_mem_model.sv ----
`timescale 1ns/1ps
module fmc_mem_model
  import fmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // engine side
  input wire fmc_mem_req_t memReq,
  output fmc_mem_rsp_t memRsp,
  // bench controls
  input wire logic [1:0] ackDelay,
  input wire logic [15:0] faultAt,
  // last attributes seen: non-temporal, privileged
  output logic [1:0] rdAttr,
  output logic [1:0] wrAttr
);
  logic [7:0] mem [256];
  logic [1:0] waitCnt;
  logic [15:0] accCnt;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      memRsp <= '0;
      waitCnt <= '0;
      accCnt <= '0;
      rdAttr <= '0;
      wrAttr <= '0;
    end
    else if (memReq.valid && !memRsp.ack && waitCnt >= ackDelay)
    begin
      memRsp.ack <= 1'b1;
      memRsp.fault <= accCnt == faultAt;
      memRsp.rdata <= (accCnt == faultAt) ? ~memRsp.rdata : mem[memReq.addr[7:0]];
      accCnt <= accCnt + 16'h1;
      waitCnt <= '0;
      if (memReq.write)
      begin
        wrAttr <= {memReq.nonTemporal, memReq.privileged};
        if (accCnt != faultAt)
          mem[memReq.addr[7:0]] <= memReq.wdata;
      end
      else
        rdAttr <= {memReq.nonTemporal, memReq.privileged};
    end
    else
    begin
      // no stale byte between answers
      memRsp.ack <= 1'b0;
      memRsp.fault <= 1'b0;
      memRsp.rdata <= ~memRsp.rdata;
      waitCnt <= (memReq.valid && !memRsp.ack) ? waitCnt + 2'h1 : 2'h0;
    end
  end
endmodule

// ---- tb/fmc_copy_engine_tb_top.sv ----
`timescale 1ns/1ps
module fmc_copy_engine_tb_top;
  import fmc_pkg::*;
  localparam logic [63:0] PLIM = 64'h6;
  localparam logic [14:0] R = {5'h2, 5'h3, 5'h1};
  logic clk;
  logic reset_n;
  fmc_apb_req_t apbReq;
  fmc_apb_rsp_t apbRsp;
  fmc_mem_req_t memReq;
  fmc_mem_rsp_t memRsp;
  logic atLowestLevel;
  logic busy;
  logic abortPulse;
  logic abortWrite;
  logic [1:0] ackDelay;
  logic [15:0] faultAt;
  logic [1:0] rdAttr;
  logic [1:0] wrAttr;
  logic [31:0] rng = 32'h29;
  logic [31:0] rdData;
  logic rdErr;
  logic [63:0] eC;
  logic [63:0] eS;
  logic [63:0] eD;
  logic [3:0] eF;
  logic [7:0] expMem [256];
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int nAbort = 0;

  fmc_copy_engine #(.BLOCK_MAX(3), .PRO_LIMIT(PLIM)) dut_u (.clk(clk), .reset_n(reset_n),
    .apbReq(apbReq), .apbRsp(apbRsp), .memReq(memReq), .memRsp(memRsp),
    .atLowestLevel(atLowestLevel), .busy(busy), .abortPulse(abortPulse),
    .abortWrite(abortWrite));
  fmc_mem_model mem_u (.clk(clk), .reset_n(reset_n), .memReq(memReq), .memRsp(memRsp),
    .ackDelay(ackDelay), .faultAt(faultAt), .rdAttr(rdAttr), .wrAttr(wrAttr));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (abortPulse === 1'b1)
      nAbort++;
    if (cycles == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  function logic [31:0] nextRand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic tally_and_finish();
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    // answer taken at the very edge where pready is seen high
    do
    begin
      @(posedge clk);
    end
    while (apbRsp.pready !== 1'b1);
    rdData = apbRsp.prdata;
    rdErr = apbRsp.pslverr;
    apbReq <= '0;
    @(posedge clk);
  endtask

  task automatic rd64(input logic [7:0] off, output logic [63:0] v);
    apb(1'b0, off, 32'h0);
    v[31:0] = rdData;
    apb(1'b0, off + 8'h4, 32'h0);
    v[63:32] = rdData;
  endtask

  task automatic wr64(input logic [7:0] off, input logic [63:0] v);
    apb(1'b1, off, v[31:0]);
    apb(1'b1, off + 8'h4, v[63:32]);
  endtask

  task automatic run(input logic [1:0] sz, input logic [1:0] stg, input logic [14:0] regs,
    input logic [3:0] ctrl, input logic [3:0] fIn, input logic [63:0] cnt,
    input logic [63:0] src, input logic [63:0] dst, input int fIdx);
    logic [3:0] opt;
    logic [63:0] left;
    logic [63:0] r;
    logic [7:0] st;
    logic [4:0] rs;
    logic [4:0] rn;
    logic [4:0] rd;
    logic b;
    int k;
    int nWr;
    int aBase;
    {rs, rn, rd} = regs;
    b = ctrl[CTRL_ALGO_B];
    void'(nextRand());
    opt = rng[3:0];
    atLowestLevel <= rng[4];
    ackDelay <= rng[6:5];
    for (k = 0; k < 256; k++)
    begin
      void'(nextRand());
      mem_u.mem[k] = rng[7:0];
      expMem[k] = rng[7:0];
    end
    faultAt <= (fIdx < 0) ? 16'hffff : mem_u.accCnt + 16'(fIdx);
    apb(1'b1, OFF_CTRL, {28'h0, ctrl});
    apb(1'b1, OFF_INSTR, {sz, 6'h19, stg, 1'b0, rs, opt, 2'h1, rn, rd});
    apb(1'b1, OFF_FLAGS, {28'h0, fIn});
    wr64(OFF_DST_LO, dst);
    wr64(OFF_SRC_LO, src);
    wr64(OFF_CNT_LO, cnt);
    st = 8'h02;
    eC = cnt;
    eS = src;
    eD = dst;
    eF = fIn;
    nWr = 0;
    aBase = nAbort;
    left = '0;
    if (!ctrl[CTRL_FEATURE] || sz != SIZE_OK)
      st[STS_UNDEF] = 1'b1;
    else if (stg == 2'h3)
      st[STS_OTHER_GROUP] = 1'b1;
    else if (rs == rn || rs == rd || rn == rd || rs == REG_ZR || rn == REG_ZR || rd == REG_ZR)
      st[ctrl[CTRL_NOP_ON_CLASH] ? STS_NOP : STS_UNDEF] = 1'b1;
    else if (stg != 2'h0 && (fIn[FLAG_C] != b || (b ? cnt[63] : cnt != 0 && !cnt[63])))
      st[STS_PARAM_ERR] = 1'b1;
    else
    begin
      if (stg == 2'h0)
      begin
        if (eC[63])
          eC = SAT_MAX;
        left = (eC < PLIM) ? eC : PLIM;
        eF = b ? 4'h2 : 4'h0;
        if (!b)
        begin
          eS = eS + eC;
          eD = eD + eC;
          eC = -eC;
        end
      end
      else
        left = b ? eC : -eC;
      for (k = 0; k < left && !st[STS_FAULT]; k++)
        if (2 * k == fIdx || 2 * k + 1 == fIdx)
          st[STS_FAULT +: 2] = {fIdx[0], 1'b1};
        else
        begin
          expMem[b ? eD[7:0] : eD[7:0] + eC[7:0]] = expMem[b ? eS[7:0] : eS[7:0] + eC[7:0]];
          nWr++;
          eC = b ? eC - 64'h1 : eC + 64'h1;
          eS = b ? eS + 64'h1 : eS;
          eD = b ? eD + 64'h1 : eD;
        end
      if (stg == 2'h2 && !st[STS_FAULT])
        eC = '0;
    end
    apb(1'b1, OFF_CTRL, {28'h0, ctrl} | 32'h1);
    if (left != 0)
    begin
      apb(1'b1, OFF_CNT_LO, 32'h0);
      check("busy write error", 64'h1, {63'h0, rdErr});
      check("busy pin", 64'h1, {63'h0, busy});
    end
    k = 0;
    do
    begin
      apb(1'b0, OFF_STATUS, 32'h0);
      k++;
    end
    while (rdData[STS_BUSY] !== 1'b0 && k < 200);
    check("status", {56'h0, st}, {32'h0, rdData});
    rd64(OFF_CNT_LO, r);
    check("count", eC, r);
    rd64(OFF_SRC_LO, r);
    check("source", eS, r);
    rd64(OFF_DST_LO, r);
    check("destination", eD, r);
    apb(1'b0, OFF_FLAGS, 32'h0);
    check("flags", {60'h0, eF}, {60'h0, rdData[3:0]});
    for (k = 0; k < 256; k++)
      check("memory", {56'h0, expMem[k]}, {56'h0, mem_u.mem[k]});
    if (nWr > 0)
    begin
      check("read attr", {62'h0, opt[3], !opt[1] && !atLowestLevel}, {62'h0, rdAttr});
      check("write attr", {62'h0, opt[2], !opt[0] && !atLowestLevel}, {62'h0, wrAttr});
    end
    check("abort pulses", {63'h0, st[STS_FAULT]}, 64'(nAbort - aBase));
    if (st[STS_FAULT])
      check("abort kind", {63'h0, st[STS_FAULT_WRITE]}, {63'h0, abortWrite});
  endtask

  initial
  begin
    reset_n = 1'b0;
    apbReq = '0;
    atLowestLevel = 1'b0;
    ackDelay = 2'h0;
    faultAt = 16'hffff;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, OFF_CTRL, 32'h0);
    check("ctrl reset", 64'h0, {32'h0, rdData});
    apb(1'b0, OFF_STATUS, 32'h0);
    check("status reset", 64'h0, {32'h0, rdData});
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", 64'h1, {63'h0, rdErr});
    run(2'h0, 2'h0, R, 4'h0, 4'h0, 64'h4, 64'h20, 64'h80, -1);
    run(2'h1, 2'h0, R, 4'h8, 4'h0, 64'h4, 64'h20, 64'h80, -1);
    run(2'h0, 2'h3, R, 4'h8, 4'h0, 64'h4, 64'h20, 64'h80, -1);
    run(2'h0, 2'h0, {5'h2, 5'h2, 5'h1}, 4'hc, 4'h0, 64'h4, 64'h20, 64'h80, -1);
    run(2'h0, 2'h1, {5'h2, 5'h3, 5'h1f}, 4'h8, 4'h0, 64'h0, 64'h20, 64'h80, -1);
    run(2'h0, 2'h1, R, 4'h8, 4'h2, 64'h0, 64'h20, 64'h80, -1);
    run(2'h0, 2'h2, R, 4'ha, 4'h2, 64'h8000_0000_0000_0002, 64'h20, 64'h80, -1);
    // source below destination, no overlap: forward copy is safe
    run(2'h0, 2'h0, R, 4'h8, 4'hf, 64'ha, 64'h20, 64'h80, -1);
    run(2'h0, 2'h1, R, 4'h8, eF, eC, eS, eD, -1);
    run(2'h0, 2'h2, R, 4'h8, eF, eC, eS, eD, -1);
    run(2'h0, 2'h0, R, 4'ha, 4'h0, 64'h9, 64'h30, 64'h90, -1);
    run(2'h0, 2'h1, R, 4'ha, eF, eC, eS, eD, 3);
    run(2'h0, 2'h2, R, 4'ha, eF, eC, eS, eD, 2);
    run(2'h0, 2'h2, R, 4'ha, eF, eC, eS, eD, -1);
    run(2'h0, 2'h0, R, 4'h8, 4'h0, 64'h8000_0000_0000_0001, 64'h40, 64'ha0, -1);
    run(2'h0, 2'h0, R, 4'ha, 4'h0, 64'h8000_0000_0000_0001, 64'h40, 64'ha0, -1);
    run(2'h0, 2'h1, R, 4'h8, 4'h0, 64'hffff_ffff_ffff_fffb, 64'h50, 64'hc0, 4);
    run(2'h0, 2'h2, R, 4'h8, 4'h0, 64'hffff_ffff_ffff_fffe, 64'h50, 64'hc0, -1);
    tally_and_finish();
  end
endmodule
